// ### testbench/branch_target_address_gen_bench.sv
`timescale 1ns/100ps

module branch_target_address_gen_bench;
    logic i_sys_clk, i_rst_n = 1'b0, i_byte_fetched = 1'b0;
    logic i_branch_valid = 1'b0, i_branch_taken = 1'b0, stall = 1'b0;
    logic [2:0] i_branch_kind = 3'h0;
    logic [7:0] i_relative_displacement = 8'h00, i_opcode = 8'h00;
    logic [15:0] i_absolute_target = 16'h0000;
    logic [15:0] i_accumulator_pair = 16'h0000, exp_pc = 16'h0000;
    logic [7:0] i_mem_rdata;
    logic i_mem_rvalid, o_table_rd, o_busy;
    logic [15:0] o_pc, o_table_addr;
    int err_count = 0, checks = 0, cycles = 0;

    branch_target_address_gen dut (
        .i_sys_clk, .i_rst_n, .i_byte_fetched, .i_branch_valid,
        .i_branch_kind, .i_branch_taken, .i_relative_displacement,
        .i_absolute_target, .i_opcode, .i_accumulator_pair, .i_mem_rdata,
        .i_mem_rvalid, .o_pc, .o_table_rd, .o_table_addr, .o_busy);
    table_memory_model mem (.i_sys_clk, .i_stall(stall), .i_rd(o_table_rd),
        .i_addr(o_table_addr), .o_rvalid(i_mem_rvalid), .o_rdata(i_mem_rdata));

    initial begin
        i_sys_clk = 1'b0;
        forever #25 i_sys_clk = ~i_sys_clk;
    end
    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            give_verdict();
        end
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic req(input logic [2:0] k);
        @(negedge i_sys_clk);
        i_branch_valid = 1'b1;
        i_branch_kind = k;
        @(negedge i_sys_clk);
        i_branch_valid = 1'b0;
    endtask : req
    task automatic give_verdict();
        $display("mismatches %0d checks %0d", err_count, checks);
        if (err_count == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_seq();
        @(negedge i_sys_clk);
        i_byte_fetched = 1'b1;
        repeat (3) @(negedge i_sys_clk);
        i_byte_fetched = 1'b0;
        exp_pc = exp_pc + 16'h0003;
        check(o_pc, exp_pc);
    endtask : t_seq
    task automatic t_rel();
        logic [7:0] d[4] = '{8'h80, 8'h7f, 8'hfe, 8'h00};
        i_branch_taken = 1'b1;
        foreach (d[i]) begin
            i_relative_displacement = d[i];
            req(3'h1);
            exp_pc = exp_pc + {{8{d[i][7]}}, d[i]};
            check(o_pc, exp_pc);
        end
        i_branch_taken = 1'b0;
        i_relative_displacement = 8'h10;
        req(3'h1);
        check(o_pc, exp_pc);
    endtask : t_rel
    task automatic t_direct();
        i_absolute_target = 16'hbeef;
        req(3'h2);
        check(o_pc, 16'hbeef);
        i_accumulator_pair = 16'h1234;
        req(3'h4);
        check(o_pc, 16'h1234);
    endtask : t_direct
    task automatic t_table(input logic [4:0] idx, input int hold);
        logic [15:0] base;
        base = 16'h0040 + {10'h000, idx, 1'b0};
        i_opcode = {2'b10, idx, 1'b1};
        stall = (hold > 0);
        req(3'h3);
        check(o_table_addr, base);
        check({15'h0000, o_busy}, 16'h0001);
        check({15'h0000, o_table_rd}, 16'h0001);
        // a request while busy must be ignored
        i_absolute_target = 16'h5555;
        req(3'h2);
        repeat (hold) @(negedge i_sys_clk);
        stall = 1'b0;
        for (int n = 0; n < 20 && o_busy !== 1'b0; n++) @(negedge i_sys_clk);
        exp_pc = {(base[7:0] + 8'h01) ^ 8'ha5, base[7:0] ^ 8'ha5};
        check(o_pc, exp_pc);
        check({o_busy, o_table_rd, 14'h0000}, 16'h0000);
    endtask : t_table

    initial begin
        repeat (10) @(negedge i_sys_clk);
        i_rst_n = 1'b1;
        check(o_pc, 16'h0000);
        t_seq();
        t_rel();
        t_direct();
        t_table(5'h00, 0);
        t_table(5'h1f, 3);
        i_rst_n = 1'b0;
        repeat (10) @(negedge i_sys_clk);
        i_rst_n = 1'b1;
        check(o_pc, 16'h0000);
        check(o_table_addr, 16'h0000);
        check({o_busy, o_table_rd, 14'h0000}, 16'h0000);
        give_verdict();
    end
endmodule : branch_target_address_gen_bench

// ### testbench/branch_target_checker.sv
`timescale 1ns/100ps

module branch_target_checker #(
    parameter int ADDR_W = 16,
    parameter int DISP_W = 8
) (
    input wire logic i_sys_clk, // clock
    input wire logic i_rst_n, // reset
    input wire logic i_byte_fetched, // fetch
    input wire logic i_branch_valid, // request
    input wire logic [2:0] i_branch_kind, // kind
    input wire logic i_branch_taken, // taken
    input wire logic [DISP_W-1:0] i_relative_displacement, // disp
    input wire logic [ADDR_W-1:0] i_absolute_target, // immediate
    input wire logic [7:0] i_opcode, // opcode
    input wire logic [ADDR_W-1:0] i_accumulator_pair, // pair
    input wire logic [7:0] i_mem_rdata, // data
    input wire logic i_mem_rvalid, // data valid
    input wire logic [ADDR_W-1:0] o_pc, // pc
    input wire logic o_table_rd, // table read
    input wire logic [ADDR_W-1:0] o_table_addr, // table address
    input wire logic o_busy // busy
);
    logic [7:0] lo;
    logic [7:0] hi;
    logic go;
    logic [15:0] sext;
    assign go = i_branch_valid && !o_busy;
    assign sext = {{8{i_relative_displacement[7]}}, i_relative_displacement};
    always_ff @(posedge i_sys_clk) begin
        if (i_mem_rvalid && !o_table_addr[0]) lo <= i_mem_rdata;
    end
    always_ff @(posedge i_sys_clk) begin
        if (i_mem_rvalid && o_table_addr[0]) hi <= i_mem_rdata;
    end
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    seq_step_a: assert property (
        !i_branch_valid && i_byte_fetched && !o_busy
        |=> o_pc == $past(o_pc) + 16'h0001) else $error("pc step wrong");
    rel_target_a: assert property (
        go && i_branch_kind == 3'h1 && i_branch_taken
        |=> o_pc == $past(o_pc) + $past(sext)) else $error("rel target");
    rel_hold_a: assert property (
        go && i_branch_kind == 3'h1 && !i_branch_taken && !i_byte_fetched
        |=> $stable(o_pc)) else $error("untaken branch moved pc");
    abs_target_a: assert property (
        go && i_branch_kind == 3'h2
        |=> o_pc == $past(i_absolute_target)) else $error("abs target");
    reg_target_a: assert property (
        go && i_branch_kind == 3'h4
        |=> o_pc == $past(i_accumulator_pair)) else $error("reg target");
    table_start_a: assert property (
        go && i_branch_kind == 3'h3 |=> o_busy && o_table_rd
        && o_table_addr == 16'h0040 + {$past(i_opcode[5:1]), 1'b0})
        else $error("table entry address");
    table_range_a: assert property (
        o_table_rd |-> o_table_addr >= 16'h0040 && o_table_addr <= 16'h007f)
        else $error("table read outside table");
    table_load_a: assert property (
        $fell(o_busy) |-> o_pc == {hi, lo}) else $error("table load");
    table_end_a: assert property (
        go && i_branch_kind == 3'h3 |-> ##[2:30] !o_busy)
        else $error("table call hung");
    cover property (go && i_branch_kind == 3'h1 && i_branch_taken);
    cover property ($fell(o_busy));
    cover property (o_busy && i_branch_valid);
endmodule : branch_target_checker

bind branch_target_address_gen branch_target_checker #(
    .ADDR_W(ADDR_W), .DISP_W(DISP_W)) checker_inst (
    .i_sys_clk, .i_rst_n, .i_byte_fetched, .i_branch_valid,
    .i_branch_kind, .i_branch_taken, .i_relative_displacement,
    .i_absolute_target, .i_opcode, .i_accumulator_pair, .i_mem_rdata,
    .i_mem_rvalid, .o_pc, .o_table_rd, .o_table_addr, .o_busy);

// ### testbench/table_memory_model.sv
`timescale 1ns/100ps

module table_memory_model (
    input wire logic i_sys_clk, // clock
    input wire logic i_stall, // hold off answers
    input wire logic i_rd, // read request
    input wire logic [15:0] i_addr, // byte address
    output logic o_rvalid, // data valid
    output logic [7:0] o_rdata // data byte
);
    logic [7:0] last = 8'h00;

    // answers in the requesting cycle unless told to stall
    assign o_rvalid = i_rd && !i_stall;
    // off a valid beat show the inverse so stale data cannot pass
    assign o_rdata = o_rvalid ? (i_addr[7:0] ^ 8'ha5) : ~last;

    always_ff @(posedge i_sys_clk) begin
        if (o_rvalid) last <= o_rdata;
    end
endmodule : table_memory_model

// ### verilog/branch_target_address_gen.sv
`timescale 1ns/100ps

// Overview of operation
// - sequential flow adds one per fetched byte
// - relative target is next start plus displacement
// - displacement is signed, bit 7 sign
// - sign extend displacement to address width
// - relative form for jump and conditional branches
// - direct call or jump loads 16-bit immediate
// - table call index from opcode bits 1-5
// - table entries live in 40H to 7FH
// - register jump loads accumulator pair
module branch_target_address_gen #(
    parameter int ADDR_W = branch_target_pkg::ADDR_W,
    parameter int DISP_W = branch_target_pkg::DISP_W
) (
    input wire logic i_sys_clk, // core clock
    input wire logic i_rst_n, // sync reset, active low
    input wire logic i_byte_fetched, // one byte fetched
    input wire logic i_branch_valid, // branch request pulse
    input wire logic [2:0] i_branch_kind, // branch_kind_e code
    input wire logic i_branch_taken, // condition satisfied
    input wire logic [DISP_W-1:0] i_relative_displacement, // signed disp
    input wire logic [ADDR_W-1:0] i_absolute_target, // 16-bit immediate
    input wire logic [7:0] i_opcode, // table call opcode
    input wire logic [ADDR_W-1:0] i_accumulator_pair, // register pair value
    input wire logic [7:0] i_mem_rdata, // program memory byte
    input wire logic i_mem_rvalid, // read data valid
    output logic [ADDR_W-1:0] o_pc, // program counter
    output logic o_table_rd, // table read request
    output logic [ADDR_W-1:0] o_table_addr, // table read address
    output logic o_busy // table call in flight
);

    // ********************************************************************
    // state
    // ********************************************************************
    branch_target_pkg::seq_state_e state;
    branch_target_pkg::seq_state_e next_state;
    logic [ADDR_W-1:0] entry_addr;
    // the two halves of a table entry as they arrive
    logic [7:0] entry_lo;
    logic [7:0] entry_hi;
    logic [ADDR_W-1:0] rel_target;
    logic [ADDR_W-1:0] next_pc;
    logic [branch_target_pkg::INDEX_W-1:0] table_index_field;
    logic rel_branch;
    logic table_req;
    logic abs_req;
    logic reg_req;

    // ********************************************************************
    // relative destination
    // ********************************************************************
    // o_pc already points past the branch, i.e. at the following instruction
    // so valid must come only after the last branch byte has been counted,
    // or the sum starts from inside the branch itself
    rel_target_adder #(
        .ADDR_W(ADDR_W),
        .DISP_W(DISP_W)
    ) u_rel_adder (
        .i_next_start(o_pc),
        .i_disp(i_relative_displacement),
        .o_target(rel_target)
    );

    // ********************************************************************
    // table entry address
    // ********************************************************************
    // five opcode bits pick one of 32 two-byte entries
    assign table_index_field = i_opcode[branch_target_pkg::INDEX_MSB:
        branch_target_pkg::INDEX_LSB];
    // doubling a 5-bit field keeps the entry inside 40H..7FH
    assign entry_addr = branch_target_pkg::TABLE_BASE
        + {{(ADDR_W-branch_target_pkg::INDEX_W-1){1'b0}},
           table_index_field, 1'b0};

    // ********************************************************************
    // request decode
    // ********************************************************************
    // unconditional relative jump counts as taken by the decoder
    assign rel_branch = i_branch_valid && i_branch_taken
        && (i_branch_kind == 3'(branch_target_pkg::KIND_REL));
    // only the table call needs more than one cycle
    assign table_req = i_branch_valid
        && (i_branch_kind == 3'(branch_target_pkg::KIND_TABLE));
    assign abs_req = i_branch_valid
        && (i_branch_kind == 3'(branch_target_pkg::KIND_ABS));
    assign reg_req = i_branch_valid
        && (i_branch_kind == 3'(branch_target_pkg::KIND_REG));

    // ********************************************************************
    // sequencer for the two-byte table read
    // ********************************************************************
    // no time-out: a memory that never answers keeps the core stalled,
    // which is cheaper than a recovery path nobody could use
    always_comb begin
        next_state = state;
        case (state)
            branch_target_pkg::ST_IDLE: begin
                if (table_req) begin
                    next_state = branch_target_pkg::ST_TAB_LO;
                end
            end
            branch_target_pkg::ST_TAB_LO: begin
                if (i_mem_rvalid) begin
                    next_state = branch_target_pkg::ST_TAB_HI;
                end
            end
            branch_target_pkg::ST_TAB_HI: begin
                if (i_mem_rvalid) begin
                    next_state = branch_target_pkg::ST_TAB_LOAD;
                end
            end
            branch_target_pkg::ST_TAB_LOAD: begin
                next_state = branch_target_pkg::ST_IDLE;
            end
            default: begin
                next_state = branch_target_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            state <= branch_target_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ********************************************************************
    // table read port
    // ********************************************************************
    // rd stands until the byte it asks for has been handed over
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_table_rd <= 1'b0;
            o_table_addr <= branch_target_pkg::PC_RESET;
        end else begin
            case (next_state)
                branch_target_pkg::ST_TAB_LO: begin
                    o_table_rd <= 1'b1;
                    if (state == branch_target_pkg::ST_IDLE) begin
                        o_table_addr <= entry_addr;
                    end
                end
                branch_target_pkg::ST_TAB_HI: begin
                    o_table_rd <= 1'b1;
                    if (state == branch_target_pkg::ST_TAB_LO) begin
                        // odd address holds the high byte
                        o_table_addr <= o_table_addr
                            + branch_target_pkg::ONE;
                    end
                end
                default: begin
                    o_table_rd <= 1'b0;
                end
            endcase
        end
    end

    // each byte has its own register so a stalled high byte read cannot
    // disturb a low byte already taken
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            entry_lo <= 8'h00;
        end else if ((state == branch_target_pkg::ST_TAB_LO)
                && i_mem_rvalid) begin
            entry_lo <= i_mem_rdata;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            entry_hi <= 8'h00;
        end else if ((state == branch_target_pkg::ST_TAB_HI)
                && i_mem_rvalid) begin
            entry_hi <= i_mem_rdata;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_busy <= 1'b0;
        end else begin
            // from next_state so busy rises on the edge that takes the call
            o_busy <= (next_state != branch_target_pkg::ST_IDLE);
        end
    end

    // ********************************************************************
    // program counter
    // ********************************************************************
    // a taken relative, direct or register branch outranks a fetch in the same cycle;
    // fetches during a table call are ignored since the fetch path is stalled by o_busy
    always_comb begin
        next_pc = o_pc;
        if (state == branch_target_pkg::ST_TAB_LOAD) begin
            next_pc = {entry_hi, entry_lo};
        end else if (state != branch_target_pkg::ST_IDLE) begin
            next_pc = o_pc;
        end else if (rel_branch) begin
            next_pc = rel_target;
        end else if (abs_req) begin
            next_pc = i_absolute_target;
        end else if (reg_req) begin
            next_pc = i_accumulator_pair;
        end else if (i_byte_fetched) begin
            next_pc = o_pc + branch_target_pkg::ONE;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_pc <= branch_target_pkg::PC_RESET;
        end else begin
            o_pc <= next_pc;
        end
    end

endmodule : branch_target_address_gen

// ### verilog/branch_target_pkg.sv
package branch_target_pkg;

    // ********************************************************************
    // widths
    // ********************************************************************
    localparam int ADDR_W = 16;
    localparam int DISP_W = 8;
    localparam int INDEX_W = 5;

    // ********************************************************************
    // reset values and fixed addresses
    // ********************************************************************
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] TABLE_BASE = 16'h0040;
    localparam logic [15:0] TABLE_LAST = 16'h007f;
    localparam logic [15:0] ONE = 16'h0001;

    // ********************************************************************
    // opcode field positions for the table call index
    // ********************************************************************
    localparam int INDEX_LSB = 1;
    localparam int INDEX_MSB = 5;

    // ********************************************************************
    // branch kinds
    // ********************************************************************
    typedef enum logic [2:0] {
        KIND_SEQ = 3'b000,
        KIND_REL = 3'b001,
        KIND_ABS = 3'b010,
        KIND_TABLE = 3'b011,
        KIND_REG = 3'b100
    } branch_kind_e;

    // ********************************************************************
    // sequencer states
    // ********************************************************************
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_TAB_LO = 4'b0010,
        ST_TAB_HI = 4'b0100,
        ST_TAB_LOAD = 4'b1000
    } seq_state_e;

endpackage : branch_target_pkg

// ### verilog/rel_target_adder.sv
`timescale 1ns/100ps

// sign extension and wrap-around addition for relative branches
module rel_target_adder #(
    parameter int ADDR_W = 16,
    parameter int DISP_W = 8
) (
    input wire logic [ADDR_W-1:0] i_next_start, // start of following instr
    input wire logic [DISP_W-1:0] i_disp, // signed displacement
    output logic [ADDR_W-1:0] o_target // branch destination
);

    logic [ADDR_W-1:0] disp_wide;

    // upper bits copy the sign bit: zeros when clear, ones when set
    assign disp_wide = {{(ADDR_W-DISP_W){i_disp[DISP_W-1]}},
        i_disp};
    // carry or borrow past the top bit is dropped by the target width
    assign o_target = i_next_start + disp_wide;

endmodule : rel_target_adder
